/* File: core/regpolicy_pkg.sv */
package regpolicy_pkg;
   // ------------------------------------------------------------
   // data unit widths and register counts
   // ------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam int WORD_BITS = 16;
   localparam int DWORD_BITS = 32;
   localparam int QWORD_BITS = 64;
   localparam int VEC_BITS = 256;
   localparam int VEC_COUNT = 16;
   localparam int VEC_LEGACY_COUNT = 8;
   localparam int GPR_COUNT = 16;
   localparam int GPR_LEGACY_COUNT = 8;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_MODE = 12'h000;
   localparam logic [11:0] ADDR_SEL = 12'h004;
   localparam logic [11:0] ADDR_DATA = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_TPR = 12'h010;
   localparam logic [11:0] ADDR_POLICY = 12'h014;
   localparam logic [11:0] ADDR_MEM = 12'h018;
   // ------------------------------------------------------------
   // field attribute masks for the policy and task priority registers, plus status, mode, select and memory constants
   // ------------------------------------------------------------
   localparam logic [31:0] POLICY_RW_MASK = 32'h0000_00FF;
   localparam logic [31:0] POLICY_IGN_MASK = 32'h0000_FF00;
   localparam logic [31:0] POLICY_RAZ_MASK = 32'h00FF_0000;
   localparam logic [31:0] POLICY_MBZ_MASK = 32'hFF00_0000;
   localparam logic [31:0] TPR_RW_MASK = 32'h0000_000F;
   localparam logic [31:0] TPR_MBZ_MASK = 32'hFFFF_FFF0;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam int STATUS_FAULT_BIT = 0;
   localparam int STATUS_UNREACH_BIT = 1;
   localparam int MODE_BITS = 3;
   localparam int SEL_GPR_BIT = 8;
   localparam int SEL_LOWBYTE_BIT = 9;
   localparam int SEL_HALF_BIT = 10;
   localparam int MEM_WORDS = 4;

   typedef enum logic [2:0] {
      MODE_REAL, MODE_PROTECTED, MODE_VIRTUAL86,
      MODE_COMPAT, MODE_LONG64
   } op_mode_type;
endpackage

/* File: core/regpolicy_bank.sv */
`timescale 1ns/1ps
// Overview of operation
// - ignored field writes discarded; reads return anything (here zero).
// - writing one into a must-be-zero field raises a fault, no commit.
// - read-as-zero fields always read zero.
// - sticky status bits hold until software writes them differently.
// - multibyte values stored little-endian, low byte at low address.
// - sixteen 256-bit vector registers, eight reachable in legacy/compat.
// - extended low-byte register views only in 64-bit mode.
// - eight General_purpose_registers at 16/32-bit size, sixteen at 64-bit, nested.
// - task priority register is control register eight.
// - word is 16 bits, quadword 64 bits.
// - long mode (64-bit, compat) or legacy (real, protected, v86).
// - byte is eight bits, doubleword 32 bits.
module regpolicy_bank
   import regpolicy_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic general_protection_fault,
   output op_mode_type op_mode
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [VEC_BITS-1:0] wide_vector_registers [VEC_COUNT];
   logic [QWORD_BITS-1:0] general_purpose_registers [GPR_COUNT];
   logic [BYTE_BITS-1:0] mem [MEM_WORDS*4];
   logic [31:0] sel, next_sel;
   logic [31:0] policy, next_policy;
   logic [31:0] task_priority_register, next_tpr;
   logic [31:0] status, next_status;
   op_mode_type next_mode;
   logic fault_q, next_fault;
   logic [31:0] rdata, next_rdata;
   logic ap_valid, next_ap_valid, ap_write, next_ap_write;
   logic [11:0] ap_addr, next_ap_addr;
   logic [2:0] vidx;
   logic [3:0] gidx;
   logic [2:0] lane;
   logic vec_ok, gpr_ok, acc_ok;
   logic [31:0] cur_word;

   // one wait state on reads: read data is registered at the end of the
   // first data-phase cycle so it reflects any write committed just before
   assign hreadyout = !(ap_valid && !ap_write);
   assign hresp = 1'b0;
   assign hrdata = rdata;
   assign general_protection_fault = fault_q;

   // ------------------------------------------------------------
   // access window decode
   // ------------------------------------------------------------
   always_comb begin
      vidx = sel[2:0];
      gidx = sel[3:0];
      lane = sel[6:4];
      // only half the vector file in legacy and compat modes
      vec_ok = (op_mode == MODE_LONG64) || (sel[3] == 1'b0);
      // upper eight General_purpose_registers only at 64-bit size
      gpr_ok = (op_mode == MODE_LONG64) || (sel[3] == 1'b0);
      // extended low-byte views only in 64-bit mode; 4 legacy ones always
      if (sel[SEL_LOWBYTE_BIT] && gidx > 4'h3 &&
          op_mode != MODE_LONG64) begin
         gpr_ok = 1'b0;
      end
      acc_ok = sel[SEL_GPR_BIT] ? gpr_ok : vec_ok;
      // 256-bit vector seen as eight 32-bit lanes, GPR as two halves
      if (sel[SEL_GPR_BIT]) begin
         if (sel[SEL_LOWBYTE_BIT]) begin
            cur_word = {24'h00_0000,
               general_purpose_registers[gidx][BYTE_BITS-1:0]};
         end else if (sel[SEL_HALF_BIT]) begin
            cur_word = general_purpose_registers[gidx][63:32];
         end else begin
            cur_word = general_purpose_registers[gidx][31:0];
         end
      end else begin
         cur_word = wide_vector_registers[{sel[3], vidx}][lane*32 +: 32];
      end
   end

   // ------------------------------------------------------------
   // bus and register next state
   // ------------------------------------------------------------
   always_comb begin
      next_ap_valid = hsel && hready && htrans[1];
      next_ap_write = hwrite;
      next_ap_addr = haddr[11:0];
      next_sel = sel;
      next_policy = policy;
      next_tpr = task_priority_register;
      next_status = status;
      next_mode = op_mode;
      next_fault = 1'b0;
      next_rdata = rdata;
      if (ap_valid && ap_write) begin
         unique case (ap_addr)
            ADDR_MODE: begin
               if (hwdata[MODE_BITS-1:0] <= 3'h4) begin
                  next_mode = op_mode_type'(hwdata[MODE_BITS-1:0]);
               end
            end
            ADDR_SEL: next_sel = hwdata & 32'h0000_077F;
            ADDR_DATA: begin
               if (!acc_ok) begin
                  next_status[STATUS_UNREACH_BIT] = 1'b1;
               end
            end
            ADDR_STATUS: next_status = hwdata & 32'h0000_0003;
            ADDR_TPR: begin
               if (|(hwdata & TPR_MBZ_MASK)) begin
                  next_fault = 1'b1;
               end else begin
                  next_tpr = hwdata & TPR_RW_MASK;
               end
            end
            ADDR_POLICY: begin
               // attribute table: mbz check, ign drop, raz not stored
               if (|(hwdata & POLICY_MBZ_MASK)) begin
                  next_fault = 1'b1;
               end else begin
                  next_policy = hwdata & POLICY_RW_MASK;
               end
            end
            default: ;
         endcase
         if (next_fault) begin
            next_status[STATUS_FAULT_BIT] = 1'b1;
         end
      end
      if (ap_valid && !ap_write) begin
         unique case (ap_addr)
            ADDR_MODE: next_rdata = {29'h0, op_mode};
            ADDR_SEL: next_rdata = sel;
            ADDR_DATA: next_rdata = acc_ok ? cur_word : 32'h0000_0000;
            ADDR_STATUS: next_rdata = status;
            ADDR_TPR: next_rdata = task_priority_register;
            // ign and raz bits both read zero
            ADDR_POLICY: next_rdata = policy & POLICY_RW_MASK;
            ADDR_MEM: next_rdata = {mem[3], mem[2], mem[1], mem[0]};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 12'h000;
         sel <= 32'h0000_0000;
         policy <= 32'h0000_0000;
         task_priority_register <= 32'h0000_0000;
         status <= STATUS_RESET;
         op_mode <= MODE_REAL;
         fault_q <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ap_valid <= next_ap_valid;
         ap_write <= next_ap_write;
         ap_addr <= next_ap_addr;
         sel <= next_sel;
         policy <= next_policy;
         task_priority_register <= next_tpr;
         status <= next_status;
         op_mode <= next_mode;
         fault_q <= next_fault;
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // register files and byte memory (no reset, data only)
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (ap_valid && ap_write && ap_addr == ADDR_DATA && acc_ok) begin
         if (sel[SEL_GPR_BIT]) begin
            if (sel[SEL_LOWBYTE_BIT]) begin
               general_purpose_registers[gidx][7:0] <= hwdata[7:0];
            end else if (sel[SEL_HALF_BIT]) begin
               general_purpose_registers[gidx][63:32] <= hwdata;
            end else begin
               general_purpose_registers[gidx][31:0] <= hwdata;
            end
         end else begin
            wide_vector_registers[{sel[3], vidx}][lane*32 +: 32] <= hwdata;
         end
      end
      if (ap_valid && ap_write && ap_addr == ADDR_MEM) begin
         mem[0] <= hwdata[7:0];
         mem[1] <= hwdata[15:8];
         mem[2] <= hwdata[23:16];
         mem[3] <= hwdata[31:24];
      end
   end
endmodule // regpolicy_bank

/* File: dv/regpolicy_bank_props.sv */
`timescale 1ns/1ps
module regpolicy_bank_props
   import regpolicy_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic general_protection_fault,
   input wire op_mode_type op_mode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic dp_wr, dp_rd, next_dp_wr, next_dp_rd, mbz_hit;
   logic [11:0] dp_addr, next_dp_addr;
   // -----------------------------
   // data phase tracking
   // -----------------------------
   always_comb begin
      next_dp_wr = hsel && hready && htrans[1] && hwrite;
      next_dp_rd = hsel && hready && htrans[1] && !hwrite;
      next_dp_addr = haddr[11:0];
      mbz_hit = (dp_addr == ADDR_TPR && |(hwdata & TPR_MBZ_MASK))
         || (dp_addr == ADDR_POLICY && |(hwdata & POLICY_MBZ_MASK));
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= 12'h000;
      end else begin
         dp_wr <= next_dp_wr;
         dp_rd <= next_dp_rd;
         dp_addr <= next_dp_addr;
      end
   end
   // -----------------------------
   // properties
   // -----------------------------
   property p_ready; !hresp && (hreadyout != dp_rd); endproperty
   a_ready: assert property (p_ready) else $error("bus not ready or error");
   property p_mbz_fault; dp_wr && mbz_hit |=> general_protection_fault;
   endproperty
   a_mbz_fault: assert property (p_mbz_fault)
      else $error("refused write gave no fault");
   property p_fault_cause;
      general_protection_fault |-> $past(dp_wr) && $past(mbz_hit);
   endproperty
   a_fault_cause: assert property (p_fault_cause)
      else $error("fault without cause");
   property p_raz_read; dp_rd && dp_addr == ADDR_POLICY |=>
      (hrdata & ~POLICY_RW_MASK) == 32'h0000_0000; endproperty
   a_raz_read: assert property (p_raz_read)
      else $error("reserved policy bits read nonzero");
   property p_tpr_read; dp_rd && dp_addr == ADDR_TPR |=>
      (hrdata & TPR_MBZ_MASK) == 32'h0000_0000; endproperty
   a_tpr_read: assert property (p_tpr_read)
      else $error("priority upper bits read nonzero");
   property p_mode_legal; op_mode <= MODE_LONG64; endproperty
   a_mode_legal: assert property (p_mode_legal)
      else $error("mode out of range");
   property p_mode_hold; !($past(dp_wr) && $past(dp_addr) == ADDR_MODE)
      |-> $stable(op_mode); endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed without write");
   property p_mode_set; dp_wr && dp_addr == ADDR_MODE && hwdata <= 32'h4
      |=> op_mode == $past(hwdata[2:0]); endproperty
   a_mode_set: assert property (p_mode_set)
      else $error("mode write not taken");
   property p_reset_vals; $rose(arst_n) |-> hrdata == 32'h0000_0000
      && !general_protection_fault && op_mode == MODE_REAL; endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("bad state after reset");
endmodule // regpolicy_bank_props
bind regpolicy_bank regpolicy_bank_props chk_u (.mclk(mclk), .arst_n(arst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .op_mode(op_mode),
   .general_protection_fault(general_protection_fault));

/* File: dv/reserved_field_access_policy_test.sv */
`timescale 1ns/1ps
module reserved_field_access_policy_test
   import regpolicy_pkg::*;
;
   logic mclk, arst_n, hsel, hwrite, hready, hreadyout, hresp, gpf;
   logic [31:0] haddr, hwdata, hrdata, rd, seed, pol;
   logic [1:0] htrans;
   logic [2:0] hsize;
   op_mode_type op_mode;
   int fail_count, compares, faults;
   assign hready = hreadyout;
   regpolicy_bank dut_u (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .general_protection_fault(gpf),
      .op_mode(op_mode));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (gpf === 1'b1) faults++;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) begin
         fail_count++;
         $display("ERROR at %0t: bus hang", $time);
         report_and_stop();
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      if (w) hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [31:0] a, exp);
      xfer(1'b0, a, 32'h0);
      check32(rd, exp);
   endtask
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, faults} = '0;
      hsize = 3'b010;
      arst_n = 1'b0;
      seed = 32'h0000_56D8;
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      rdchk(ADDR_MODE, 32'h0);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         pol = (i == 0) ? 32'h00FF_FFFF : seed & ~POLICY_MBZ_MASK;
         xfer(1'b1, ADDR_POLICY, pol);
         xfer(1'b0, ADDR_POLICY, 32'h0);
         check32(rd & ~POLICY_IGN_MASK, pol & POLICY_RW_MASK);
         xfer(1'b1, ADDR_POLICY, rd);
         xfer(1'b0, ADDR_POLICY, 32'h0);
         check32(rd & ~POLICY_IGN_MASK, pol & POLICY_RW_MASK);
      end
      $display("policy attribute test done");
      xfer(1'b1, ADDR_TPR, 32'h0000_0005);
      xfer(1'b1, ADDR_TPR, 32'h8000_000A);
      xfer(1'b1, ADDR_POLICY, 32'h0100_0033);
      rdchk(ADDR_TPR, 32'h0000_0005);
      xfer(1'b0, ADDR_POLICY, 32'h0);
      check32(rd & ~POLICY_IGN_MASK, pol & POLICY_RW_MASK);
      check32(32'(faults), 32'h2);
      rdchk(ADDR_STATUS, 32'h1);
      xfer(1'b1, ADDR_TPR, 32'h0000_0003);
      rdchk(ADDR_STATUS, 32'h1);
      xfer(1'b1, ADDR_STATUS, 32'h0);
      rdchk(ADDR_STATUS, 32'h0);
      $display("refusal and sticky test done");
      for (int m = 0; m < 5; m++) begin
         xfer(1'b1, ADDR_MODE, 32'(m));
         rdchk(ADDR_MODE, 32'(m));
         check32({29'h0, op_mode}, 32'(m));
      end
      xfer(1'b1, ADDR_MODE, 32'h7);
      check32({29'h0, op_mode}, 32'h4);
      $display("mode test done");
      xfer(1'b1, ADDR_MODE, 32'h4);
      xfer(1'b1, ADDR_SEL, 32'h0000_0108);
      xfer(1'b1, ADDR_DATA, 32'hA5A5_0001);
      rdchk(ADDR_DATA, 32'hA5A5_0001);
      xfer(1'b1, ADDR_SEL, 32'h0000_0508);
      xfer(1'b1, ADDR_DATA, 32'h0000_0077);
      rdchk(ADDR_DATA, 32'h0000_0077);
      xfer(1'b1, ADDR_SEL, 32'h0000_0308);
      rdchk(ADDR_DATA, 32'h0000_0001);
      xfer(1'b1, ADDR_SEL, 32'h0000_0028);
      xfer(1'b1, ADDR_DATA, seed);
      rdchk(ADDR_DATA, seed);
      xfer(1'b1, ADDR_MODE, 32'h3);
      rdchk(ADDR_DATA, 32'h0);
      xfer(1'b1, ADDR_SEL, 32'h0000_0308);
      rdchk(ADDR_DATA, 32'h0);
      xfer(1'b1, ADDR_SEL, 32'h0000_0108);
      xfer(1'b1, ADDR_DATA, 32'h0000_5555);
      rdchk(ADDR_STATUS, 32'h2);
      xfer(1'b1, ADDR_MODE, 32'h4);
      rdchk(ADDR_DATA, 32'hA5A5_0001);
      xfer(1'b1, ADDR_SEL, 32'h0000_0102);
      xfer(1'b1, ADDR_DATA, 32'h1234_5678);
      xfer(1'b1, ADDR_MODE, 32'h1);
      rdchk(ADDR_DATA, 32'h1234_5678);
      $display("register reach test done");
      seed = xs(seed);
      xfer(1'b1, ADDR_MEM, seed);
      rdchk(ADDR_MEM, seed);
      rdchk(32'h0000_0FFC, 32'h0);
      $display("memory and unmapped test done");
      report_and_stop();
   end
endmodule // reserved_field_access_policy_test
